// ===== src/fpr_pkg.sv
package fpr_pkg;

   // Clock of the sequencer
   localparam int CLK_NS = 8;

   // Minimum times, in ns, as given for the flash
   localparam int CORE_SETTLE_NS    = 50000;
   localparam int IO_SETTLE_NS      = 50000;
   localparam int CLR_TO_SEL_NS     = 50000;
   localparam int CLR_PULSE_NS      = 200;
   localparam int CLR_HIGH_SEL_NS   = 50;
   localparam int READY_TO_ACC_NS   = 0;
   localparam int SEL_HIGH_NS       = 20;

   // Least times round up, never below one cycle
   function automatic int cyc_up(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int CORE_SETTLE_CYC   = cyc_up(CORE_SETTLE_NS);
   localparam int IO_SETTLE_CYC     = cyc_up(IO_SETTLE_NS);
   localparam int SETTLE_CYC        = (CORE_SETTLE_CYC > IO_SETTLE_CYC) ?
                                      CORE_SETTLE_CYC : IO_SETTLE_CYC;
   localparam int CLR_TO_SEL_CYC    = cyc_up(CLR_TO_SEL_NS);
   localparam int CLR_PULSE_CYC     = cyc_up(CLR_PULSE_NS);
   localparam int CLR_HIGH_SEL_CYC  = cyc_up(CLR_HIGH_SEL_NS);
   localparam int READY_TO_ACC_CYC  = cyc_up(READY_TO_ACC_NS);
   localparam int SEL_HIGH_CYC      = cyc_up(SEL_HIGH_NS);

   // Counter widths
   localparam int CNT_W  = 16;
   localparam int HCNT_W = 4;

   // Sequencer states
   typedef enum logic [2:0] {
      ST_OFF,
      ST_SETTLE,
      ST_CLR_LOW,
      ST_CLR_HIGH,
      ST_WAIT_DONE,
      ST_READY
   } fpr_state_t;

   // Pins toward the flash
   typedef struct packed {
      logic clear_n;
      logic sel_n;
   } fpr_pins_t;

   // Status toward the user
   typedef struct packed {
      logic ready;
      logic in_reset;
      logic dev_busy;
   } fpr_status_t;

   // Whole state of the sequencer
   typedef struct packed {
      fpr_state_t         state;
      logic [CNT_W-1:0]   cnt;
      logic [HCNT_W-1:0]  hcnt;
      fpr_pins_t          pins;
      fpr_status_t        stat;
   } fpr_regs_t;

   localparam fpr_regs_t REGS_RST = '{
      state: ST_OFF,
      cnt:   '0,
      hcnt:  '0,
      pins:  '{clear_n: 1'b1, sel_n: 1'b1},
      stat:  '{ready: 1'b0, in_reset: 1'b1, dev_busy: 1'b1}
   };

endpackage

// ===== src/fpr_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser, one chain per bit
module fpr_sync #(
   parameter int W = 2
) (
   // Clock and control
   input  wire logic         clk_sys,
   input  wire logic         sys_rst,
   input  wire logic         clk_en,
   // Asynchronous levels in, synchronised levels out
   input  wire logic [W-1:0] async_in,
   output var  logic [W-1:0] sync_out
);

   logic [W-1:0] meta_reg;

   // First flop feeds only the second
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk_sys) begin
            if (sys_rst) begin
               meta_reg[i] <= 1'b0;
               sync_out[i] <= 1'b0;
            end else if (clk_en) begin
               meta_reg[i] <= async_in[i];
               sync_out[i] <= meta_reg[i];
            end
         end
      end
   endgenerate

endmodule

`default_nettype wire

// ===== src/fpr_seq.sv
// Functional notes
// - Wait 50 us after both supplies reach minimum before first access.
// - Wait at least 50 us from clear low to chip select low.
// - Clear asserted during power-up still lasts 200 ns and keeps the wait.
// - Clear stays high at least 50 ns before chip select goes low.
// - Clear pulse plus clear-high wait must cover the clear-to-select time.
// - Select may fall 0 ns after the done flag rises.
// - Chip select stays high at least 20 ns each time it is released.
// - With clear during power-up, select waits for the latest of all settle times.
// - A falling select edge is needed after power-up before valid reads.
`timescale 1ns/1ps
`default_nettype none

module fpr_seq #(
   parameter int SETTLE_CYC     = fpr_pkg::SETTLE_CYC,
   parameter int CLR_TO_SEL_CYC = fpr_pkg::CLR_TO_SEL_CYC
) (
   // Clock, reset and enable
   input  wire logic                 clk_sys,
   input  wire logic                 sys_rst,
   input  wire logic                 clk_en,
   // Board side, asynchronous
   input  wire logic                 supply_good,
   input  wire logic                 done_flag,
   // User side, same clock
   input  wire logic                 hold_clear_at_power,
   input  wire logic                 warm_req,
   input  wire logic                 sel_req,
   // Flash pins
   output var  fpr_pkg::fpr_pins_t   pins,
   // Status
   output var  fpr_pkg::fpr_status_t status
);

   // Clear-high wait so that pulse plus wait covers the clear-to-select time
   localparam int HIGH_RAW  = CLR_TO_SEL_CYC - fpr_pkg::CLR_PULSE_CYC;
   localparam int HIGH_CYC  = (HIGH_RAW > fpr_pkg::CLR_HIGH_SEL_CYC) ?
                              HIGH_RAW : fpr_pkg::CLR_HIGH_SEL_CYC;

   localparam logic [fpr_pkg::CNT_W-1:0]  SETTLE_LD = fpr_pkg::CNT_W'(SETTLE_CYC - 1);
   localparam logic [fpr_pkg::CNT_W-1:0]  PULSE_LD  =
      fpr_pkg::CNT_W'(fpr_pkg::CLR_PULSE_CYC - 1);
   localparam logic [fpr_pkg::CNT_W-1:0]  HIGH_LD   = fpr_pkg::CNT_W'(HIGH_CYC - 1);
   localparam logic [fpr_pkg::CNT_W-1:0]  RB_LD     =
      fpr_pkg::CNT_W'(fpr_pkg::READY_TO_ACC_CYC - 1);
   localparam logic [fpr_pkg::HCNT_W-1:0] SELH_LD   =
      fpr_pkg::HCNT_W'(fpr_pkg::SEL_HIGH_CYC - 1);
   localparam logic [fpr_pkg::CNT_W-1:0]  CNT_ZERO  = '0;
   localparam logic [fpr_pkg::HCNT_W-1:0] HCNT_ZERO = '0;
   localparam logic [fpr_pkg::CNT_W-1:0]  CNT_ONE   = fpr_pkg::CNT_W'(1);
   localparam logic [fpr_pkg::HCNT_W-1:0] HCNT_ONE  = fpr_pkg::HCNT_W'(1);

   fpr_pkg::fpr_regs_t r_reg;
   fpr_pkg::fpr_regs_t r_next;
   logic [1:0]         sync_q;
   logic               pwr_s;
   logic               done_s;

   // Supply and done flag come from the board, so both are synchronised
   fpr_sync #(
      .W (2)
   ) u_sync (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .clk_en   (clk_en),
      .async_in ({supply_good, done_flag}),
      .sync_out (sync_q)
   );

   assign pwr_s  = sync_q[1];
   assign done_s = sync_q[0];

   // Next-state logic of the whole sequencer
   always_comb begin
      r_next = r_reg;
      r_next.stat.dev_busy = ~done_s;
      unique case (r_reg.state)
         fpr_pkg::ST_OFF: begin
            r_next.pins.sel_n = 1'b1;
            r_next.pins.clear_n = 1'b1;
            if (pwr_s) begin
               // Supply up: optional clear during the settle period
               r_next.state = fpr_pkg::ST_SETTLE;
               r_next.cnt = SETTLE_LD;
               r_next.pins.clear_n = ~hold_clear_at_power;
            end
         end
         fpr_pkg::ST_SETTLE: begin
            // Select held high: the flash would ignore it anyway
            r_next.pins.sel_n = 1'b1;
            if (r_reg.cnt == CNT_ZERO) begin
               if (!r_reg.pins.clear_n) begin
                  // Clear still low: restart clear timing at settle end
                  r_next.state = fpr_pkg::ST_CLR_LOW;
                  r_next.cnt = PULSE_LD;
               end else begin
                  r_next.state = fpr_pkg::ST_WAIT_DONE;
                  r_next.cnt = RB_LD;
               end
            end else begin
               r_next.cnt = r_reg.cnt - CNT_ONE;
            end
         end
         fpr_pkg::ST_CLR_LOW: begin
            r_next.pins.clear_n = 1'b0;
            if (r_reg.cnt == CNT_ZERO) begin
               r_next.pins.clear_n = 1'b1;
               r_next.state = fpr_pkg::ST_CLR_HIGH;
               r_next.cnt = HIGH_LD;
            end else begin
               r_next.cnt = r_reg.cnt - CNT_ONE;
            end
         end
         fpr_pkg::ST_CLR_HIGH: begin
            if (r_reg.cnt == CNT_ZERO) begin
               r_next.state = fpr_pkg::ST_WAIT_DONE;
               r_next.cnt = RB_LD;
            end else begin
               r_next.cnt = r_reg.cnt - CNT_ONE;
            end
         end
         fpr_pkg::ST_WAIT_DONE: begin
            // The flash holds done low until its routine ends
            if (done_s) begin
               if (r_reg.cnt == CNT_ZERO) begin
                  r_next.state = fpr_pkg::ST_READY;
               end else begin
                  r_next.cnt = r_reg.cnt - CNT_ONE;
               end
            end
         end
         fpr_pkg::ST_READY: begin
            if (!r_reg.pins.sel_n) begin
               if (!sel_req) begin
                  r_next.pins.sel_n = 1'b1;
                  r_next.hcnt = SELH_LD;
               end
            end else if (r_reg.hcnt != HCNT_ZERO) begin
               r_next.hcnt = r_reg.hcnt - HCNT_ONE;
            end else if (warm_req) begin
               // Warm clear only starts with select released
               r_next.state = fpr_pkg::ST_CLR_LOW;
               r_next.pins.clear_n = 1'b0;
               r_next.cnt = PULSE_LD;
            end else if (sel_req) begin
               r_next.pins.sel_n = 1'b0;
            end
         end
         default: begin
            r_next.state = fpr_pkg::ST_OFF;
         end
      endcase
      // Supply loss overrides everything and restarts the cold sequence
      if (!pwr_s) begin
         r_next.state = fpr_pkg::ST_OFF;
         r_next.pins.sel_n = 1'b1;
         r_next.pins.clear_n = 1'b1;
         r_next.hcnt = HCNT_ZERO;
      end
      r_next.stat.ready = (r_next.state == fpr_pkg::ST_READY);
      r_next.stat.in_reset = (r_next.state != fpr_pkg::ST_READY);
   end

   // State register; clock enable freezes everything
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         r_reg <= fpr_pkg::REGS_RST;
      end else if (clk_en) begin
         r_reg <= r_next;
      end
   end

   // Outputs come straight from the state register
   assign pins   = r_reg.pins;
   assign status = r_reg.stat;

endmodule

`default_nettype wire

// ===== verif/fpr_seq_properties.sv
`timescale 1ns/1ps
`default_nettype none
module fpr_seq_properties #(
   parameter int SETTLE_CYC     = 40,
   parameter int CLR_TO_SEL_CYC = 40
) (
   // Clock and reset
   input wire logic                 clk_sys,
   input wire logic                 sys_rst,
   // Watched ports
   input wire logic                 supply_good,
   input wire logic                 done_flag,
   input wire logic                 warm_req,
   input wire logic                 sel_req,
   input wire fpr_pkg::fpr_pins_t   pins,
   input wire fpr_pkg::fpr_status_t status
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   int up_c;
   int lo_c;
   int hi_c;
   int fall_c;
   // Run lengths; a run this short never wraps an int
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         up_c   <= 0;
         lo_c   <= 0;
         hi_c   <= 0;
         fall_c <= 1 << 20;
      end else begin
         up_c   <= supply_good ? up_c + 1 : 0;
         lo_c   <= pins.clear_n ? 0 : lo_c + 1;
         hi_c   <= pins.clear_n ? hi_c + 1 : 0;
         fall_c <= (!pins.clear_n && lo_c == 0) ? 1 : fall_c + 1;
      end
   end
   property p_sel_ready;
      !pins.sel_n |-> status.ready;
   endproperty
   a_sel_ready: assert property (p_sel_ready) else $error("select low while not ready");
   property p_sel_settle;
      $fell(pins.sel_n) |-> up_c >= SETTLE_CYC;
   endproperty
   a_sel_settle: assert property (p_sel_settle) else $error("select before settle");
   property p_clr_pulse;
      $rose(pins.clear_n) |-> lo_c >= fpr_pkg::CLR_PULSE_CYC;
   endproperty
   a_clr_pulse: assert property (p_clr_pulse) else $error("clear pulse short");
   property p_clr_high;
      $fell(pins.sel_n) |-> hi_c >= fpr_pkg::CLR_HIGH_SEL_CYC;
   endproperty
   a_clr_high: assert property (p_clr_high) else $error("clear high too short");
   property p_clr_to_sel;
      $fell(pins.sel_n) |-> fall_c >= CLR_TO_SEL_CYC;
   endproperty
   a_clr_to_sel: assert property (p_clr_to_sel) else $error("clear to select short");
   property p_sel_high;
      $rose(pins.sel_n) |=> pins.sel_n [*2];
   endproperty
   a_sel_high: assert property (p_sel_high) else $error("select high too short");
   property p_ready_done;
      $rose(status.ready) |-> $past(done_flag, 3);
   endproperty
   a_ready_done: assert property (p_ready_done) else $error("ready without done");
   property p_warm_go;
      status.ready && warm_req && !sel_req && pins.sel_n && $past(pins.sel_n)
         && $past(pins.sel_n, 2) && $past(pins.sel_n, 3)
         && supply_good && $past(supply_good, 2) && $past(supply_good, 3)
         |=> !pins.clear_n && !status.ready;
   endproperty
   a_warm_go: assert property (p_warm_go) else $error("warm clear not started");
endmodule
`default_nettype wire

// ===== verif/fpr_flash_mdl.sv
`timescale 1ns/1ps
`default_nettype none
// Flash reset behaviour only; the clock just times its routines
module fpr_flash_mdl #(
   parameter int COLD_CYC = 30,
   parameter int WARM_CYC = 60
) (
   // Timer clock
   input  wire logic clk_sys,
   // Board and host pins; select is never looked at
   input  wire logic supply_good,
   input  wire logic clear_n,
   input  wire logic sel_n,
   // Ready/busy toward the host
   output var  logic done_flag
);
   int cnt = 0;
   initial done_flag = 1'b0;
   // Clear and select are ignored while a routine counts down; supply loss still restarts it
   always @(posedge clk_sys) begin
      if (!supply_good) begin
         cnt       <= COLD_CYC;
         done_flag <= 1'b0;
      end else if (cnt > 0) begin
         cnt       <= cnt - 1;
         done_flag <= 1'b0;
      end else if (!clear_n && done_flag) begin
         // Warm clear only follows a finished routine, cold or warm
         cnt       <= WARM_CYC;
         done_flag <= 1'b0;
      end else begin
         done_flag <= clear_n;
      end
   end
endmodule
`default_nettype wire

// ===== verif/fpr_seq_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fpr_seq_tb;
   localparam int SET_C  = 40;
   localparam int CTS_C  = 40;
   localparam int WARM_C = 60;
   logic                 clk_sys     = 1'b0;
   logic                 sys_rst     = 1'b1;
   logic                 supply_good = 1'b0;
   logic                 hold_clr    = 1'b0;
   logic                 warm_req    = 1'b0;
   logic                 sel_req     = 1'b0;
   logic                 clk_en      = 1'b1;
   logic                 done_flag;
   fpr_pkg::fpr_pins_t   pins;
   fpr_pkg::fpr_status_t status;
   int                   n_mismatch   = 0;
   int                   total_checks = 0;
   int                   cyc          = 0;
   // Clock, 8 ns period
   always #4 clk_sys = ~clk_sys;
   fpr_seq #(.SETTLE_CYC(SET_C), .CLR_TO_SEL_CYC(CTS_C)) u_dut (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
      .supply_good(supply_good), .done_flag(done_flag),
      .hold_clear_at_power(hold_clr), .warm_req(warm_req),
      .sel_req(sel_req), .pins(pins), .status(status));
   // Slow warm routine so the host has to wait on the done flag
   fpr_flash_mdl #(.COLD_CYC(30), .WARM_CYC(WARM_C)) u_flash (
      .clk_sys(clk_sys), .supply_good(supply_good),
      .clear_n(pins.clear_n), .sel_n(pins.sel_n), .done_flag(done_flag));
   task automatic wrap_up();
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // Bounded wait on clear_n (w=1) or ready (w=0), counting edges
   task automatic wait_for(input int w, input logic lvl, output int n);
      n = 0;
      while ((w ? pins.clear_n : status.ready) !== lvl && n < 500) begin
         cycles(1);
         n++;
      end
      // A wait that runs out is a mismatch, not a silent pass
      if (n >= 500) begin
         n_mismatch++;
         $display("[FAIL] wait_for expected %0h seen timeout", lvl);
      end
   endtask
   task automatic t_cold();
      int n;
      @(posedge clk_sys) supply_good <= 1'b1;
      wait_for(0, 1'b1, n);
      chk("cold_wait_ok", 1, n >= SET_C);
      chk("clear_n", 1, pins.clear_n);
      chk("in_reset", 0, status.in_reset);
      chk("dev_busy", 0, status.dev_busy);
      @(posedge clk_sys) sel_req <= 1'b1;
      cycles(1);
      chk("sel_n", 0, pins.sel_n);
      @(posedge clk_sys) sel_req <= 1'b0;
      cycles(1);
      chk("sel_n", 1, pins.sel_n);
   endtask
   // Warm request while selected must be refused; select must be released first
   task automatic t_refuse();
      @(posedge clk_sys) sel_req <= 1'b1;
      cycles(4);
      chk("sel_n", 0, pins.sel_n);
      @(posedge clk_sys) warm_req <= 1'b1;
      cycles(4);
      chk("clear_n", 1, pins.clear_n);
      chk("ready", 1, status.ready);
      @(posedge clk_sys) warm_req <= 1'b0;
      @(posedge clk_sys) sel_req <= 1'b0;
   endtask
   task automatic t_warm();
      int n;
      int m;
      cycles(6);
      @(posedge clk_sys) warm_req <= 1'b1;
      @(posedge clk_sys) warm_req <= 1'b0;
      #1 chk("clear_n", 0, pins.clear_n);
      chk("ready", 0, status.ready);
      wait_for(1, 1'b1, n);
      chk("clr_low", fpr_pkg::CLR_PULSE_CYC, n);
      chk("dev_busy", 1, status.dev_busy);
      wait_for(0, 1'b1, m);
      chk("warm_wait_ok", 1, n + m >= CTS_C && n + m >= WARM_C);
   endtask
   // Supply loss, then power-up with clear held
   task automatic t_hold();
      int n;
      @(posedge clk_sys) supply_good <= 1'b0;
      cycles(6);
      chk("ready", 0, status.ready);
      chk("clear_n", 1, pins.clear_n);
      @(posedge clk_sys) hold_clr <= 1'b1;
      @(posedge clk_sys) supply_good <= 1'b1;
      wait_for(1, 1'b0, n);
      wait_for(1, 1'b1, n);
      chk("hold_low", SET_C + fpr_pkg::CLR_PULSE_CYC, n);
      @(posedge clk_sys) hold_clr <= 1'b0;
      wait_for(0, 1'b1, n);
      chk("ready", 1, status.ready);
      // Clock enable low freezes the select request until it returns
      @(posedge clk_sys) clk_en <= 1'b0;
      sel_req <= 1'b1;
      cycles(4);
      chk("sel_n_frozen", 1, pins.sel_n);
      @(posedge clk_sys) clk_en <= 1'b1;
      cycles(2);
      chk("sel_n", 0, pins.sel_n);
      @(posedge clk_sys) sel_req <= 1'b0;
   endtask
   initial begin
      repeat (10) @(posedge clk_sys);
      sys_rst <= 1'b0;
      t_cold();
      t_refuse();
      t_warm();
      t_hold();
      wrap_up();
   end
   // Hang guard
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_mismatch++;
         $display("[FAIL] run_length expected %0d seen %0d", 3000, cyc);
         wrap_up();
      end
   end
endmodule
bind fpr_seq fpr_seq_properties #(
   .SETTLE_CYC(SETTLE_CYC), .CLR_TO_SEL_CYC(CLR_TO_SEL_CYC)
) u_props (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .supply_good(supply_good),
   .done_flag(done_flag), .warm_req(warm_req), .sel_req(sel_req),
   .pins(pins), .status(status));
`default_nettype wire
